// ### hw/epc_params.svh
// Purpose: Named constants for the EPROM programming controller.
// Assumes: 40 MHz clock, 25 ns period.
// Notes:   Times are kept in their own units; pulse and access cycle counts derive from them, setup is given in cycles.
`ifndef EPC_PARAMS_SVH
`define EPC_PARAMS_SVH
`define EPC_CLK_MHZ        40
`define EPC_PULSE_US       100
`define EPC_PULSE_CYC      (`EPC_PULSE_US * `EPC_CLK_MHZ)
`define EPC_MAX_PULSES     4'hA
`define EPC_SETUP_CYC      16'h0004
`define EPC_ACCESS_NS      200
`define EPC_ACCESS_CYC     ((`EPC_ACCESS_NS * `EPC_CLK_MHZ + 999) / 1000)
`define EPC_ADDR_W         17
`define EPC_ADDR_LAST      17'h1FFFF
`define EPC_ERASED_BYTE    8'hFF
`define EPC_ADDR_ZERO      17'h00000
`define EPC_ADDR_ONE       17'h00001
`endif

// ### hw/epc_pkg.sv
// Purpose: Types shared by the EPROM programming controller.
// Assumes: Constants come from epc_params.svh.
// Notes:   Pin group and result group travel as packed structs.
package epc_pkg;
  // Commands from the user side.
  typedef enum logic [2:0] {
    EPC_CMD_READ    = 3'h0,
    EPC_CMD_PROGRAM = 3'h1,
    EPC_CMD_IDENT   = 3'h2,
    EPC_CMD_CHECK   = 3'h3
  } epc_cmd_e;

  // Controller states, Gray coded in listed order.
  typedef enum logic [2:0] {
    EPC_IDLE   = 3'b000,
    EPC_SETUP  = 3'b001,
    EPC_PULSE  = 3'b011,
    EPC_RECOV  = 3'b010,
    EPC_VERIFY = 3'b110,
    EPC_READ   = 3'b111,
    EPC_DONE   = 3'b101
  } epc_state_e;

  // Pins driven toward the device.
  typedef struct packed {
    logic [16:0] addr;
    logic        chip_select_n;
    logic        output_enable_n;
    logic        program_strobe_n;
    logic        vpp_high;
    logic        vcc_raised;
    logic        identifier_select_pin;
  } epc_pins_s;

  // Result toward the user side.
  typedef struct packed {
    logic [7:0] data;
    logic       fail;
    logic [3:0] pulses;
  } epc_result_s;
endpackage

// ### hw/epc_timer.sv
// Purpose: Down counter timing strobe widths and setup delays.
// Assumes: Loaded with a nonzero count.
// Notes:   expired is high while the count is zero.
`timescale 1ns/1ps
`default_nettype none
module epc_timer (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        load,
  input  wire logic [15:0] count,
  output logic             expired
);
  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;

  // Load wins over counting; counting stops at zero.
  // The load edge is the first counted cycle, so the count starts one short.
  // That way expired is seen exactly count cycles after the load, not one late.
  always_comb begin
    cnt_next = cnt_reg;
    if (load) begin
      cnt_next = count - 16'h0001;
    end else if (cnt_reg != 16'h0000) begin
      cnt_next = cnt_reg - 16'h0001;
    end
  end

  // Registers only; the enable freezes the count.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cnt_reg <= 16'h0000;
    end else if (ce) begin
      cnt_reg <= cnt_next;
    end
  end

  assign expired = (cnt_reg == 16'h0000);
endmodule // epc_timer
`default_nettype wire

// ### hw/epc_ctrl.sv
// Purpose: Host controller that reads, identifies and programs an EPROM.
// Assumes: Supply switching hardware follows vpp_high and vcc_raised.
// Notes:   Data lines are split into input, output and output enable.
`timescale 1ns/1ps
`default_nettype none
`include "epc_params.svh"
module epc_ctrl import epc_pkg::*; (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire logic              ce,
  input  wire logic              cmd_valid,
  output logic                   cmd_ready,
  input  wire epc_cmd_e          cmd,
  input  wire logic [16:0]       cmd_addr,
  input  wire logic [7:0]        cmd_data,
  output logic                   rsp_valid,
  output epc_result_s            rsp,
  output epc_pins_s              pins,
  input  wire logic [7:0]        data_lines_i,
  output logic [7:0]             data_lines_o,
  output logic                   data_lines_oe
);
  epc_state_e  state_reg, state_next;
  epc_cmd_e    op_reg, op_next;
  epc_pins_s   pins_reg, pins_next;
  epc_result_s res_reg, res_next;
  logic [7:0]  wdata_reg, wdata_next;
  logic        oe_reg, oe_next;
  logic        rv_reg, rv_next;
  logic [7:0]  sync1_reg, sync2_reg;
  logic        t_load;
  logic [15:0] t_count;
  logic        t_done;

  // Idle pin state: selected off, supplies normal, strobe high.
  function automatic epc_pins_s idle_pins();
    epc_pins_s p;
    p = '0;
    p.chip_select_n    = 1'b1;
    p.output_enable_n  = 1'b1;
    p.program_strobe_n = 1'b1;
    return p;
  endfunction

  // Data lines come from another domain, so two flops precede use.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync1_reg <= 8'h00;
      sync2_reg <= 8'h00;
    end else if (ce) begin
      sync1_reg <= data_lines_i;
      sync2_reg <= sync1_reg;
    end
  end

  epc_timer u_timer (
    .clk     (clk),
    .nrst    (nrst),
    .ce      (ce),
    .load    (t_load),
    .count   (t_count),
    .expired (t_done)
  );

  // Sequencer: setup, strobe, recovery, verify, loop or finish.
  always_comb begin
    state_next = state_reg;
    op_next    = op_reg;
    pins_next  = pins_reg;
    res_next   = res_reg;
    wdata_next = wdata_reg;
    oe_next    = oe_reg;
    rv_next    = 1'b0;
    t_load     = 1'b0;
    t_count    = `EPC_SETUP_CYC;
    case (state_reg)
      EPC_IDLE: begin
        if (cmd_valid) begin
          op_next        = cmd;
          wdata_next     = cmd_data;
          res_next       = '0;
          pins_next      = idle_pins();
          pins_next.addr = cmd_addr;
          t_load         = 1'b1;
          state_next     = EPC_SETUP;
          if (cmd == EPC_CMD_PROGRAM) begin
            pins_next.vpp_high      = 1'b1;
            pins_next.vcc_raised    = 1'b1;
            pins_next.chip_select_n = 1'b0;
            oe_next                 = 1'b1;
          end else if (cmd == EPC_CMD_IDENT) begin
            pins_next.addr                  = cmd_addr[0] ? `EPC_ADDR_ONE : `EPC_ADDR_ZERO;
            pins_next.identifier_select_pin = 1'b1;
          end
        end
      end
      EPC_SETUP: begin
        if (t_done) begin
          if (op_reg == EPC_CMD_PROGRAM) begin
            pins_next.program_strobe_n = 1'b0;
            t_load     = 1'b1;
            t_count    = 16'(`EPC_PULSE_CYC);
            res_next.pulses = res_reg.pulses + 4'h1;
            state_next = EPC_PULSE;
          end else begin
            pins_next.chip_select_n   = 1'b0;
            pins_next.output_enable_n = 1'b0;
            t_load     = 1'b1;
            t_count    = 16'(`EPC_ACCESS_CYC);
            state_next = EPC_READ;
          end
        end
      end
      EPC_PULSE: begin
        if (t_done) begin
          pins_next.program_strobe_n = 1'b1;
          oe_next    = 1'b0;
          t_load     = 1'b1;
          state_next = EPC_RECOV;
        end
      end
      EPC_RECOV: begin
        if (t_done) begin
          pins_next.output_enable_n = 1'b0;
          t_load     = 1'b1;
          t_count    = 16'(`EPC_ACCESS_CYC);
          state_next = EPC_VERIFY;
        end
      end
      EPC_VERIFY: begin
        if (t_done) begin
          res_next.data             = sync2_reg;
          pins_next.output_enable_n = 1'b1;
          if (sync2_reg == wdata_reg) begin
            state_next = EPC_DONE;
          end else if (res_reg.pulses == `EPC_MAX_PULSES) begin
            res_next.fail = 1'b1;
            state_next    = EPC_DONE;
          end else begin
            oe_next    = 1'b1;
            t_load     = 1'b1;
            state_next = EPC_SETUP;
          end
        end
      end
      EPC_READ: begin
        if (t_done) begin
          res_next.data = sync2_reg;
          if (op_reg == EPC_CMD_CHECK) begin
            res_next.fail = (sync2_reg != wdata_reg);
          end
          state_next = EPC_DONE;
        end
      end
      EPC_DONE: begin
        pins_next  = idle_pins();
        oe_next    = 1'b0;
        rv_next    = 1'b1;
        state_next = EPC_IDLE;
      end
      default: begin
        state_next = EPC_IDLE;
      end
    endcase
  end

  // Registers of the sequencer; ce freezes everything.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_reg <= EPC_IDLE;
      op_reg    <= EPC_CMD_READ;
      pins_reg  <= '{addr: `EPC_ADDR_ZERO, chip_select_n: 1'b1, output_enable_n: 1'b1,
                     program_strobe_n: 1'b1, default: 1'b0};
      res_reg   <= '0;
      wdata_reg <= `EPC_ERASED_BYTE;
      oe_reg    <= 1'b0;
      rv_reg    <= 1'b0;
    end else if (ce) begin
      state_reg <= state_next;
      op_reg    <= op_next;
      pins_reg  <= pins_next;
      res_reg   <= res_next;
      wdata_reg <= wdata_next;
      oe_reg    <= oe_next;
      rv_reg    <= rv_next;
    end
  end

  assign cmd_ready     = (state_reg == EPC_IDLE);
  assign rsp_valid     = rv_reg;
  assign rsp           = res_reg;
  assign pins          = pins_reg;
  assign data_lines_o  = wdata_reg;
  assign data_lines_oe = oe_reg;

  // Host never drives data while the device output is enabled.
  bus_contention_a: assert property (@(posedge clk) disable iff (!nrst)
    !(data_lines_oe && !pins.output_enable_n && !pins.chip_select_n))
    else $error("data driven during device read");
  // Strobe low only with vpp_high raised and data driven and stable.
  strobe_setup_a: assert property (@(posedge clk) disable iff (!nrst)
    $fell(pins.program_strobe_n) |-> pins.vpp_high && data_lines_oe && $stable(data_lines_o))
    else $error("strobe without programming setup");
  // Pulse count never exceeds ten.
  pulse_limit_a: assert property (@(posedge clk) disable iff (!nrst)
    res_reg.pulses <= `EPC_MAX_PULSES)
    else $error("too many program pulses");
  // Verify reads keep the strobe high.
  verify_strobe_a: assert property (@(posedge clk) disable iff (!nrst)
    !pins.output_enable_n |-> pins.program_strobe_n)
    else $error("strobe low during read");
  // Done returns pins to idle and answers.
  done_idle_a: assert property (@(posedge clk) disable iff (!nrst)
    ce && state_reg == EPC_DONE |=> rsp_valid && pins.chip_select_n && !pins.vpp_high)
    else $error("done did not release device");
  // The strobe is low only in the timed pulse state, so its width is the timer's.
  strobe_state_a: assert property (@(posedge clk) disable iff (!nrst)
    !pins.program_strobe_n |-> state_reg == EPC_PULSE)
    else $error("strobe low outside pulse state");
  // Plain reads and final checks run with both supplies back at normal level.
  read_supply_a: assert property (@(posedge clk) disable iff (!nrst)
    state_reg == EPC_READ |-> !pins.vpp_high && !pins.vcc_raised)
    else $error("read with raised supplies");
endmodule // epc_ctrl
`default_nettype wire

// ### verification/epc_eprom_model.sv
// Purpose: Behavioural EPROM that answers the controller's pins.
// Assumes: Pins change only on controller clock edges.
// Notes:   Weak cells need pulses_needed strobes before they take data.
`timescale 1ns/1ps
`default_nettype none
module epc_eprom_model import epc_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'h3C, // Arbitrary value.
  parameter logic [7:0] PART_ID  = 8'hA5  // Arbitrary value.
) (
  input  wire epc_pins_s  pins,
  input  wire logic [7:0] host_q,
  input  wire logic [3:0] pulses_needed,
  output logic [7:0]      dev_q,
  output logic            dev_oe
);
  logic [7:0] mem [logic [16:0]];
  logic [3:0] hits = 4'h0;

  // Locations never written read as ones, as after erasure.
  function automatic logic [7:0] peek(input logic [16:0] a);
    return mem.exists(a) ? mem[a] : 8'hFF;
  endfunction

  // Select high is standby and enable high floats the lines.
  always_comb begin
    dev_oe = !pins.chip_select_n && !pins.output_enable_n;
    if (pins.identifier_select_pin) begin
      dev_q = pins.addr[0] ? PART_ID : MAKER_ID;
    end else begin
      dev_q = peek(pins.addr);
    end
  end

  // A strobe programs only under raised supplies, select low, enable high.
  // Leaving the byte clears the tally; one process keeps a single driver.
  always @(negedge pins.program_strobe_n or posedge pins.chip_select_n) begin
    if (pins.chip_select_n) begin
      hits = 4'h0;
    end else if (pins.vpp_high && pins.vcc_raised && pins.output_enable_n) begin
      hits = hits + 4'h1;
      if (hits >= pulses_needed) begin
        mem[pins.addr] = peek(pins.addr) & host_q;
      end
    end
  end
endmodule // epc_eprom_model
`default_nettype wire

// ### verification/epc_ctrl_tb.sv
// Purpose: Self-checking bench for the EPROM programming controller.
// Assumes: Full 100 us pulses; whole run stays near 60000 cycles.
// Notes:   Undriven data lines toggle so stale values never pass.
`timescale 1ns/1ps
`default_nettype none
module epc_ctrl_tb import epc_pkg::*;;
  typedef struct packed {
    epc_cmd_e    cmd;
    logic [16:0] addr;
    logic [7:0]  data;
    logic [3:0]  need;
    logic [7:0]  exp;
    logic        fail;
    logic [3:0]  pulses;
  } epc_row_s;
  localparam int PULSE_CYC = 100000 / 25;
  localparam epc_row_s ROWS [10] = '{
    '{EPC_CMD_READ,    17'h00000, 8'h00, 4'h1, 8'hFF, 1'b0, 4'h0},
    '{EPC_CMD_IDENT,   17'h00000, 8'h00, 4'h1, 8'h3C, 1'b0, 4'h0},
    '{EPC_CMD_IDENT,   17'h00001, 8'h00, 4'h1, 8'hA5, 1'b0, 4'h0},
    '{EPC_CMD_PROGRAM, 17'h1FFFF, 8'hA5, 4'h1, 8'hA5, 1'b0, 4'h1},
    '{EPC_CMD_READ,    17'h1FFFF, 8'h00, 4'h1, 8'hA5, 1'b0, 4'h0},
    '{EPC_CMD_CHECK,   17'h1FFFF, 8'hA5, 4'h1, 8'hA5, 1'b0, 4'h0},
    '{EPC_CMD_CHECK,   17'h1FFFF, 8'h00, 4'h1, 8'hA5, 1'b1, 4'h0},
    '{EPC_CMD_PROGRAM, 17'h1FFFF, 8'hFF, 4'h1, 8'hA5, 1'b1, 4'hA},
    '{EPC_CMD_PROGRAM, 17'h00002, 8'h0F, 4'h3, 8'h0F, 1'b0, 4'h3},
    '{EPC_CMD_READ,    17'h00002, 8'h00, 4'h1, 8'h0F, 1'b0, 4'h0}
  };
  logic        clk;
  logic        nrst;
  logic        ce;
  logic        cmd_valid;
  logic        cmd_ready;
  epc_cmd_e    cmd;
  logic [16:0] cmd_addr;
  logic [7:0]  cmd_data;
  logic        rsp_valid;
  epc_result_s rsp;
  epc_pins_s   pins;
  logic [7:0]  data_lines_o;
  logic        data_lines_oe;
  logic [7:0]  dev_q;
  logic        dev_oe;
  logic [3:0]  need;
  logic [7:0]  float_pat = 8'h5A;
  wire  [7:0]  bus = data_lines_oe ? data_lines_o : (dev_oe ? dev_q : float_pat);
  int          errors = 0;
  int          check_count = 0;
  int          low_len = 0;

  epc_ctrl i_epc_ctrl (.clk(clk), .nrst(nrst), .ce(ce), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd(cmd), .cmd_addr(cmd_addr), .cmd_data(cmd_data), .rsp_valid(rsp_valid), .rsp(rsp), .pins(pins),
    .data_lines_i(bus), .data_lines_o(data_lines_o), .data_lines_oe(data_lines_oe));
  epc_eprom_model i_epc_eprom_model (.pins(pins), .host_q(bus), .pulses_needed(need), .dev_q(dev_q),
    .dev_oe(dev_oe));

  // Clock at 40 MHz.
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      errors++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask

  task automatic final_report();
    if (errors == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // Issues one command at a falling edge, optionally freezing it with ce.
  task automatic run_cmd(input epc_row_s r, input int stall);
    int n;
    chk(cmd_ready === 1'b1, "not ready in idle");
    need = r.need;
    cmd_valid = 1'b1;
    cmd = r.cmd;
    cmd_addr = r.addr;
    cmd_data = r.data;
    @(negedge clk);
    cmd_valid = 1'b0;
    ce = (stall == 0);
    repeat (stall) begin
      @(negedge clk);
      chk(rsp_valid === 1'b0, "answer while frozen");
      chk(cmd_ready === 1'b0, "ready while busy");
    end
    ce = 1'b1;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 50000) begin
      @(negedge clk);
      n++;
    end
    chk(rsp_valid === 1'b1, "no answer in time");
    chk(rsp.data === r.exp && rsp.fail === r.fail && pins.chip_select_n === 1'b1, "bad answer");
    if (r.cmd == EPC_CMD_PROGRAM) chk(rsp.pulses === r.pulses, "pulse count");
  endtask

  // Strobe only with raised supplies and driven data; each pulse lasts 100 us.
  always @(posedge clk) begin
    float_pat <= ~float_pat;
    if (!nrst) begin
      low_len = 0;
    end else begin
      chk(!(data_lines_oe && dev_oe), "bus contention");
      if (pins.program_strobe_n === 1'b0) begin
        low_len++;
        chk(pins.vpp_high && pins.vcc_raised && !pins.chip_select_n && pins.output_enable_n
            && data_lines_oe, "strobe outside programming");
      end else if (low_len != 0) begin
        chk(low_len == PULSE_CYC, "pulse width");
        low_len = 0;
      end
    end
  end

  // Main sequence: reset, table rows, then frozen and aborted commands.
  initial begin
    nrst = 1'b0;
    ce = 1'b1;
    cmd_valid = 1'b0;
    cmd = EPC_CMD_READ;
    cmd_addr = 17'h00000;
    cmd_data = 8'h00;
    need = 4'h1;
    repeat (8) @(negedge clk);
    chk(pins.chip_select_n && pins.program_strobe_n && !pins.vpp_high && !data_lines_oe && !rsp_valid, "reset");
    nrst = 1'b1;
    foreach (ROWS[i]) run_cmd(ROWS[i], 0);
    run_cmd(ROWS[9], 40);
    cmd_valid = 1'b1;
    cmd = EPC_CMD_PROGRAM;
    cmd_addr = 17'h00003;
    @(negedge clk);
    cmd_valid = 1'b0;
    repeat (200) @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    chk(pins.program_strobe_n && pins.chip_select_n && !pins.vpp_high && !pins.vcc_raised, "abort");
    nrst = 1'b1;
    run_cmd(ROWS[0], 0);
    final_report();
  end

  // Watchdog sized well above the roughly 60000 cycles of the sequence.
  initial begin
    repeat (90000) @(posedge clk);
    errors++;
    $display("Error %0t: watchdog expired", $time);
    final_report();
  end
endmodule // epc_ctrl_tb
`default_nettype wire
